// ### frame_fifo.sv
// small synchronous fifo for received frames
`timescale 1ns/1ps
module frame_fifo #(
    parameter int WIDTH = 32,
    parameter int DEPTH = 4
) (
    input  wire logic             ref_clk_in,
    input  wire logic             srst_in,
    input  wire logic             ce_in,
    input  wire logic             in_valid_in,
    output logic                  in_ready_out,
    input  wire logic [WIDTH-1:0] in_data_in,
    output logic                  out_valid_out,
    input  wire logic             out_ready_in,
    output logic [WIDTH-1:0]      out_data_out
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    if (WIDTH < 1 || DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_param
        $error("fifo width or depth out of range");
    end
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0]      wr_ptr;
    logic [AW:0]      rd_ptr;
    logic [AW:0]      next_wr_ptr;
    logic [AW:0]      next_rd_ptr;
    logic             do_wr;
    logic             do_rd;
    always_comb begin
        in_ready_out  = (wr_ptr - rd_ptr) != (AW + 1)'(DEPTH);
        out_valid_out = wr_ptr != rd_ptr;
        out_data_out  = mem[rd_ptr[AW-1:0]];
        do_wr         = in_valid_in && in_ready_out;
        do_rd         = out_valid_out && out_ready_in;
        next_wr_ptr   = wr_ptr + (AW + 1)'(do_wr);
        next_rd_ptr   = rd_ptr + (AW + 1)'(do_rd);
    end
    always_ff @(posedge ref_clk_in) begin
        if (srst_in) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
        end else if (ce_in) begin
            wr_ptr <= next_wr_ptr;
            rd_ptr <= next_rd_ptr;
            if (do_wr) begin
                mem[wr_ptr[AW-1:0]] <= in_data_in;
            end
        end
    end
endmodule

// ### spi_frame_pkg.sv
// shared constants for the serial frame slave
package spi_frame_pkg;
    localparam int FRAME_BITS        = 32;
    localparam int CLK_MHZ           = 200;
    localparam int FILTER_TIME_NS    = 500;
    localparam int FILTER_CYCLES     = (FILTER_TIME_NS * CLK_MHZ + 999) / 1000;
    localparam int FIFO_DEPTH        = 4;
    localparam logic [31:0] IDLE_REPLY = 32'h00000000;
    localparam int BIT_CNT_W         = 5;
endpackage

// ### spi_host_model.sv
// serial master model driving the slave pins
`timescale 1ns/1ps
module spi_host_model (
    input  wire logic ref_clk_in,
    input  wire logic sdo_in,
    input  wire logic sdo_oe_in,
    output logic      sclk_out,
    output logic      sdi_out,
    output logic      select_low_out
);
    initial begin
        sclk_out = 1'b0;
        sdi_out = 1'b1;
        select_low_out = 1'b1;
    end
    // nb clocks, msb first; half period of 5 ref cycles leaves room for the sync flops
    task automatic xfer(input int nb, input logic [63:0] tx, output logic [63:0] rx);
        rx = '0;
        select_low_out = 1'b0;
        repeat (8) @(negedge ref_clk_in);
        for (int i = nb - 1; i >= 0; i--) begin
            sclk_out = 1'b1;
            sdi_out = tx[i];
            repeat (5) @(negedge ref_clk_in);
            sclk_out = 1'b0;
            rx[i] = sdo_oe_in ? sdo_in : 1'bz;
            repeat (5) @(negedge ref_clk_in);
        end
        select_low_out = 1'b1;
        sdi_out = 1'b1;
        repeat (12) @(negedge ref_clk_in);
    endtask
endmodule

// ### spi_slave_daisy_chain.sv
// serial frame slave with daisy chain path, pin filters and frame fifo
//
// Operation
// - frames are 32 bits, full duplex, and a transfer may be any multiple of 32 clocks.
// - mode 1: clock idles low, input is captured on the second edge of each bit.
// - select is active low and the slave only responds while it is low.
// - received frames configure the device and status returns on the same link.
// - in a chain all slaves share the select and output feeds the next input.
// - data passes through the 32-bit shift path, one frame per 32 clocks.
// - reset and both disable inputs ignore pulses shorter than the filter time.
// - frames shift most significant bit first both ways.
// - the answer to a frame is returned during the next frame.
// - the last bit of each frame is odd parity, generated and checked; the IDLE_REPLY answer of all zeros goes out with even parity.
// - in reset the output is released and clock and input are ignored.
`timescale 1ns/1ps
module spi_slave_daisy_chain
    import spi_frame_pkg::*;
#(
    parameter int FILTER_LEN = FILTER_CYCLES,
    parameter int DEPTH      = FIFO_DEPTH
) (
    input  wire logic        ref_clk_in,
    input  wire logic        srst_in,
    input  wire logic        ce_in,
    input  wire logic        sclk_in,
    input  wire logic        sdi_in,
    input  wire logic        select_low_in,
    output logic             sdo_out,
    output logic             sdo_oe_out,
    input  wire logic        hard_reset_pin_in,
    input  wire logic        shutoff_request_high_in,
    input  wire logic        shutoff_request_low_bidir_in,
    output logic             hard_reset_active_out,
    output logic             shutoff_high_out,
    output logic             shutoff_low_out,
    output logic             frame_valid_out,
    output logic [31:0]      frame_data_out,
    output logic             frame_parity_ok_out,
    input  wire logic        frame_ready_in,
    input  wire logic [31:0] reply_data_in,
    output logic             overflow_out
);
    if (FILTER_LEN < 1 || DEPTH < 2) begin : g_bad_param
        $error("filter length or fifo depth out of range");
    end
    localparam int FW = $clog2(FILTER_LEN + 1);
    localparam int NPIN = 6;

    // all pins pass two flops before use
    logic [NPIN-1:0] sync1;
    logic [NPIN-1:0] sync2;
    logic [NPIN-1:0] sync3;
    always_ff @(posedge ref_clk_in) begin
        if (srst_in) begin
            // idle pin levels, so no false edge follows reset
            sync1 <= 6'h1e;
            sync2 <= 6'h1e;
            sync3 <= 6'h1e;
        end else if (ce_in) begin
            sync1 <= {shutoff_request_low_bidir_in, shutoff_request_high_in,
                      hard_reset_pin_in, select_low_in, sdi_in, sclk_in};
            sync2 <= sync1;
            sync3 <= sync2;
        end
    end
    logic sdi_s, sel_s;
    logic sclk_rise, sclk_fall, sel_rise, sel_fall;
    always_comb begin
        sdi_s     = sync2[1];
        sel_s     = sync2[2];
        sclk_rise = sync2[0] && !sync3[0];
        sclk_fall = !sync2[0] && sync3[0];
        sel_rise  = sync2[2] && !sync3[2];
        sel_fall  = !sync2[2] && sync3[2];
    end

    // glitch filters: a level only changes after staying stable long enough
    logic [2:0]    filt;
    logic [2:0]    next_filt;
    logic [FW-1:0] fcnt [3];
    logic [FW-1:0] next_fcnt [3];
    genvar gi;
    generate
        for (gi = 0; gi < 3; gi++) begin : g_filt
            always_comb begin
                next_filt[gi] = filt[gi];
                next_fcnt[gi] = '0;
                if (sync2[3+gi] != filt[gi]) begin
                    next_fcnt[gi] = fcnt[gi] + FW'(1);
                    if (fcnt[gi] >= FW'(FILTER_LEN - 1)) begin
                        next_filt[gi] = sync2[3+gi];
                        next_fcnt[gi] = '0;
                    end
                end
            end
            always_ff @(posedge ref_clk_in) begin
                if (srst_in) begin
                    filt[gi] <= (gi == 2) ? 1'b0 : 1'b1;
                    fcnt[gi] <= '0;
                end else if (ce_in) begin
                    filt[gi] <= next_filt[gi];
                    fcnt[gi] <= next_fcnt[gi];
                end
            end
        end
    endgenerate
    logic in_reset;
    always_comb in_reset = !filt[0];

    // frame shifter
    logic [31:0]          shreg, next_shreg;
    logic [31:0]          reply, next_reply;
    logic [BIT_CNT_W-1:0] bcnt, next_bcnt;
    logic                 aligned, next_aligned;
    logic                 odd_bits, next_odd_bits;
    logic                 sdo, next_sdo;
    logic                 oe, next_oe;
    logic                 push;
    logic                 push_ready;
    logic                 ovf, next_ovf;
    logic                 pop_valid;
    logic [31:0]          pop_data;
    always_comb begin
        next_shreg    = shreg;
        next_reply    = reply;
        next_bcnt     = bcnt;
        next_aligned  = aligned;
        next_odd_bits = odd_bits;
        next_sdo      = sdo;
        next_oe       = oe;
        next_ovf      = ovf;
        push          = 1'b0;
        if (in_reset) begin
            next_oe      = 1'b0;
            next_bcnt    = '0;
            next_aligned = 1'b0;
            next_reply   = IDLE_REPLY;
        end else if (sel_fall) begin
            next_oe       = 1'b1;
            next_bcnt     = '0;
            next_aligned  = 1'b0;
            next_odd_bits = 1'b0;
            next_shreg    = reply;
            next_sdo      = reply[31];
        end else if (!sel_s) begin
            if (sclk_fall) begin
                next_shreg = {shreg[30:0], sdi_s};
                next_bcnt  = bcnt + BIT_CNT_W'(1);
                next_aligned = (bcnt == BIT_CNT_W'(FRAME_BITS - 1));
                // mid-frame flag, cleared again at every 32-bit boundary
                next_odd_bits = (bcnt != BIT_CNT_W'(FRAME_BITS - 1));
            end
            if (sclk_rise && !(bcnt == '0 && !aligned && !odd_bits)) begin
                next_sdo = shreg[31];
            end
        end else if (sel_rise) begin
            next_oe = 1'b0;
            if (aligned && !odd_bits) begin
                push = 1'b1;
                if (!push_ready) begin
                    next_ovf = 1'b1;
                end
                // parity bad frames get the empty answer
                next_reply = (^shreg) ? {reply_data_in[31:1], ~^reply_data_in[31:1]}
                                      : IDLE_REPLY;
            end else begin
                next_reply = IDLE_REPLY;
            end
        end
    end
    always_ff @(posedge ref_clk_in) begin
        if (srst_in) begin
            shreg    <= '0;
            reply    <= IDLE_REPLY;
            bcnt     <= '0;
            aligned  <= 1'b0;
            odd_bits <= 1'b0;
            sdo      <= 1'b0;
            oe       <= 1'b0;
            ovf      <= 1'b0;
        end else if (ce_in) begin
            shreg    <= next_shreg;
            reply    <= next_reply;
            bcnt     <= next_bcnt;
            aligned  <= next_aligned;
            odd_bits <= next_odd_bits;
            sdo      <= next_sdo;
            oe       <= next_oe;
            ovf      <= next_ovf;
        end
    end

    // fifo decouples frame commits from a slow consumer
    frame_fifo #(
        .WIDTH (32),
        .DEPTH (DEPTH)
    ) u_fifo (
        .ref_clk_in    (ref_clk_in),
        .srst_in       (srst_in),
        .ce_in         (ce_in),
        .in_valid_in   (push),
        .in_ready_out  (push_ready),
        .in_data_in    (shreg),
        .out_valid_out (pop_valid),
        .out_ready_in  (!frame_valid_out || frame_ready_in),
        .out_data_out  (pop_data)
    );

    // registered output stage; valid never waits for ready
    logic        fv, next_fv;
    logic [31:0] fd, next_fd;
    logic        fp, next_fp;
    logic        rst_flag, next_rst_flag;
    logic        low_flag, next_low_flag;
    always_comb begin
        next_fv = fv && !frame_ready_in;
        next_fd = fd;
        if (pop_valid && (!fv || frame_ready_in)) begin
            next_fv = 1'b1;
            next_fd = pop_data;
        end
        next_fp       = ^next_fd;
        next_rst_flag = !next_filt[0];
        next_low_flag = !next_filt[2];
    end
    always_ff @(posedge ref_clk_in) begin
        if (srst_in) begin
            fv       <= 1'b0;
            fd       <= '0;
            fp       <= 1'b0;
            rst_flag <= 1'b0;
            low_flag <= 1'b1;
        end else if (ce_in) begin
            fv       <= next_fv;
            fd       <= next_fd;
            fp       <= next_fp;
            rst_flag <= next_rst_flag;
            low_flag <= next_low_flag;
        end
    end
    always_comb begin
        frame_valid_out       = fv;
        frame_data_out        = fd;
        frame_parity_ok_out   = fp;
        sdo_out               = sdo;
        sdo_oe_out            = oe;
        hard_reset_active_out = rst_flag;
        shutoff_high_out      = filt[1];
        shutoff_low_out       = low_flag;
        overflow_out          = ovf;
    end
endmodule

// ### spi_slave_daisy_chain_asserts.sv
// concurrent checks on the serial slave ports
`timescale 1ns/1ps
module spi_slave_daisy_chain_asserts #(
    parameter int FILTER_LEN = 100
) (
    input wire logic        ref_clk_in,
    input wire logic        srst_in,
    input wire logic        ce_in,
    input wire logic        select_low_in,
    input wire logic        sdo_oe_out,
    input wire logic        hard_reset_pin_in,
    input wire logic        shutoff_request_high_in,
    input wire logic        hard_reset_active_out,
    input wire logic        shutoff_high_out,
    input wire logic        frame_valid_out,
    input wire logic [31:0] frame_data_out,
    input wire logic        frame_parity_ok_out,
    input wire logic        frame_ready_in,
    input wire logic        overflow_out
);
    default clocking @(posedge ref_clk_in); endclocking
    default disable iff (srst_in);
    // run lengths of the active pin levels, so any filter length can be checked
    int rst_low_run;
    int shut_low_run;
    always_ff @(posedge ref_clk_in) begin
        if (srst_in || !ce_in || hard_reset_pin_in) begin
            rst_low_run <= 0;
        end else begin
            rst_low_run <= rst_low_run + 1;
        end
        if (srst_in || !ce_in || shutoff_request_high_in) begin
            shut_low_run <= 0;
        end else begin
            shut_low_run <= shut_low_run + 1;
        end
    end
    // five cycles cover the two sync flops plus the output register
    chk_oe_idle: assert property ((select_low_in && ce_in)[*5] |-> !sdo_oe_out)
        else $error("output driven while deselected");
    chk_oe_selected: assert property (
        (!select_low_in && !hard_reset_active_out && ce_in)[*5] |-> sdo_oe_out)
        else $error("output released while selected");
    chk_oe_in_reset: assert property (hard_reset_active_out[*2] |-> !sdo_oe_out)
        else $error("output driven in reset");
    chk_valid_holds: assert property (
        frame_valid_out && !frame_ready_in && ce_in |=> frame_valid_out && $stable(frame_data_out))
        else $error("frame dropped before taken");
    chk_parity_flag: assert property (frame_valid_out |-> frame_parity_ok_out == ^frame_data_out)
        else $error("parity flag wrong");
    // two sync flops and the filter run; the outputs add no cycle
    chk_reset_pin_follow: assert property (
        rst_low_run > FILTER_LEN + 2 |-> hard_reset_active_out)
        else $error("reset pin not followed");
    chk_shutoff_follow: assert property (
        shut_low_run > FILTER_LEN + 2 |-> !shutoff_high_out)
        else $error("shutoff pin not followed");
    chk_short_pulse: assert property (!$stable(shutoff_high_out) |->
        $past(shutoff_request_high_in, 3) == shutoff_high_out
        && $past(shutoff_request_high_in, 4) == shutoff_high_out)
        else $error("short pulse passed filter");
    cover property ($fell(sdo_oe_out) ##[1:20] $rose(frame_valid_out));
    cover property ($rose(overflow_out));
    cover property ($fell(shutoff_high_out));
endmodule

bind spi_slave_daisy_chain spi_slave_daisy_chain_asserts #(.FILTER_LEN(FILTER_LEN)) u_chk (
    .ref_clk_in, .srst_in, .ce_in,
    .select_low_in, .sdo_oe_out, .hard_reset_pin_in, .shutoff_request_high_in,
    .hard_reset_active_out, .shutoff_high_out, .frame_valid_out, .frame_data_out,
    .frame_parity_ok_out, .frame_ready_in, .overflow_out);

// ### spi_slave_daisy_chain_test.sv
// self-checking bench for the serial frame slave
`timescale 1ns/1ps
module spi_slave_daisy_chain_test;
    import spi_frame_pkg::*;
    logic        ref_clk_in, srst_in, ce_in, sclk_in, sdi_in, select_low_in, sdo_out;
    logic        sdo_oe_out, hard_reset_pin_in, shutoff_request_high_in;
    logic        shutoff_request_low_bidir_in, hard_reset_active_out, shutoff_high_out;
    logic        shutoff_low_out, frame_valid_out, frame_parity_ok_out, frame_ready_in;
    logic        overflow_out;
    logic [31:0] frame_data_out, reply_data_in, w;
    logic [63:0] rx;
    int          num_errors = 0;
    int          num_checks = 0;

    spi_slave_daisy_chain #(.FILTER_LEN(4)) DUT (.ref_clk_in, .srst_in, .ce_in, .sclk_in,
        .sdi_in, .select_low_in, .sdo_out, .sdo_oe_out, .hard_reset_pin_in,
        .shutoff_request_high_in, .shutoff_request_low_bidir_in, .hard_reset_active_out,
        .shutoff_high_out, .shutoff_low_out, .frame_valid_out, .frame_data_out,
        .frame_parity_ok_out, .frame_ready_in, .reply_data_in, .overflow_out);
    spi_host_model host (.ref_clk_in, .sdo_in(sdo_out), .sdo_oe_in(sdo_oe_out),
        .sclk_out(sclk_in), .sdi_out(sdi_in), .select_low_out(select_low_in));

    initial begin
        ref_clk_in = 1'b0;
        forever #2.5 ref_clk_in = ~ref_clk_in;
    end

    function automatic logic [31:0] odd(input logic [31:0] v);
        return {v[31:1], ~^v[31:1]};
    endfunction

    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        num_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(negedge ref_clk_in);
    endtask

    // bounded wait, then pop; the trailing cycle keeps ready low between pops
    task automatic take(output logic [31:0] v);
        for (int i = 0; i < 40 && frame_valid_out !== 1'b1; i++) cyc(1);
        v = frame_valid_out === 1'b1 ? frame_data_out : 'x;
        frame_ready_in = 1'b1;
        cyc(1);
        frame_ready_in = 1'b0;
        cyc(1);
    endtask

    task automatic t_frames;
        reply_data_in = 32'h5a5a_00f0;
        host.xfer(32, odd(32'h1234_5678), rx);
        check(rx[31:0], 32'h0);
        check(frame_parity_ok_out, 1'b1);
        take(w);
        check(w, odd(32'h1234_5678));
        reply_data_in = 32'h0;
        host.xfer(64, {odd(32'hc3c3_0001), odd(32'h8765_4321)}, rx);
        check(rx, {odd(32'h5a5a_00f0), odd(32'hc3c3_0001)});
        take(w);
        check(w, odd(32'h8765_4321));
        $display("frame test done");
    endtask

    task automatic t_refuse;
        host.xfer(31, 64'h0, rx);
        cyc(20);
        check(frame_valid_out, 1'b0);
        host.xfer(32, 64'h8000_0001, rx);
        check(rx[31:0], 32'h0);
        check(frame_parity_ok_out, 1'b0);
        // clock enable low must freeze the handshake
        ce_in = 1'b0;
        frame_ready_in = 1'b1;
        cyc(3);
        frame_ready_in = 1'b0;
        ce_in = 1'b1;
        check(frame_valid_out, 1'b1);
        take(w);
        check(w, 32'h8000_0001);
        host.xfer(32, odd(32'h0), rx);
        check(rx[31:0], 32'h0);
        take(w);
        check(w, odd(32'h0));
        $display("refusal test done");
    endtask

    task automatic t_fifo;
        for (int i = 0; i < 7; i++) host.xfer(32, odd(32'(i) << 4), rx);
        check(overflow_out, 1'b1);
        for (int i = 0; i < 4; i++) begin
            take(w);
            check(w, odd(32'(i) << 4));
        end
        // four in the fifo plus one in the output stage
        take(w);
        check(w, odd(32'h40));
        cyc(5);
        check(frame_valid_out, 1'b0);
        $display("fifo test done");
    endtask

    task automatic t_pins;
        shutoff_request_high_in = 1'b0;
        cyc(2);
        shutoff_request_high_in = 1'b1;
        cyc(12);
        check(shutoff_high_out, 1'b1);
        shutoff_request_high_in = 1'b0;
        shutoff_request_low_bidir_in = 1'b1;
        cyc(12);
        check({shutoff_high_out, shutoff_low_out}, 2'b00);
        shutoff_request_high_in = 1'b1;
        shutoff_request_low_bidir_in = 1'b0;
        hard_reset_pin_in = 1'b0;
        cyc(12);
        check(hard_reset_active_out, 1'b1);
        host.xfer(32, odd(32'h0), rx);
        check(rx[31:0], 32'hzzzz_zzzz);
        check(frame_valid_out, 1'b0);
        hard_reset_pin_in = 1'b1;
        cyc(12);
        host.xfer(32, odd(32'h0), rx);
        check(rx[31:0], 32'h0);
        take(w);
        check(w, odd(32'h0));
        $display("pin test done");
    endtask

    task automatic finish_test;
        $display("checks %0d mismatches %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    initial begin
        srst_in = 1'b1;
        ce_in = 1'b1;
        hard_reset_pin_in = 1'b1;
        shutoff_request_high_in = 1'b1;
        shutoff_request_low_bidir_in = 1'b0;
        frame_ready_in = 1'b0;
        reply_data_in = 32'h0;
        cyc(8);
        srst_in = 1'b0;
        cyc(20);
        t_frames();
        t_refuse();
        t_fifo();
        t_pins();
        finish_test();
    end

    // about 5200 cycles expected; generous margin
    initial begin
        #200000;
        num_errors++;
        $display("mismatch at %0t: watchdog expired", $time);
        finish_test();
    end
endmodule
